// ---- hw/aam_alarm_monitor.sv ----
// alarm monitor top: sticky event flags, masks, summary bit and calibration status pin
`include "aam_map.svh"
`default_nettype none
module aam_alarm_monitor #(
    parameter int DIV_W = 4  // width of the divider phase words compared
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             soft_reset_i,
    // serial register port pins
    input  wire logic             spi_cs_n_i,
    input  wire logic             spi_sclk_i,
    input  wire logic             spi_sdi_i,
    output logic                  spi_sdo_o,
    output logic                  spi_sdo_oe_o,
    // clocking events from the converter core
    input  wire logic             realign_pulse_i,
    input  wire logic [DIV_W-1:0] div_phase_a_i,
    input  wire logic [DIV_W-1:0] div_phase_b_i,
    // calibration status pin
    input  wire logic             cal_status_sel_i,
    input  wire logic             cal_done_i,
    output logic                  cal_stat_o,
    // state for the core
    output logic                  summary_alarm_o
);
    aam_regbus_if bus ();

    // serial port front end
    aam_spi_port u_spi (
        .clk_sys_i    (clk_sys_i),
        .rst_n_i      (rst_n_i),
        .spi_cs_n_i   (spi_cs_n_i),
        .spi_sclk_i   (spi_sclk_i),
        .spi_sdi_i    (spi_sdi_i),
        .spi_sdo_o    (spi_sdo_o),
        .spi_sdo_oe_o (spi_sdo_oe_o),
        .bus          (bus.port_side)
    );

    aam_pkg::aam_byte_t event_flag_register_ff;
    aam_pkg::aam_byte_t nxt_event_flag_register;
    aam_pkg::aam_byte_t event_mask_register_ff;
    aam_pkg::aam_byte_t nxt_event_mask_register;
    logic               cal_stat_ff;

    // address decode of the three registers
    wire logic sel_summary_w = bus.addr == `AAM_ADDR_SUMMARY;
    wire logic sel_flags_w   = bus.addr == `AAM_ADDR_FLAGS;
    wire logic sel_mask_w    = bus.addr == `AAM_ADDR_MASK;
    wire logic wr_flags_w    = bus.wr_stb && sel_flags_w;
    wire logic wr_mask_w     = bus.wr_stb && sel_mask_w;

    // named flag and mask bits
    wire logic realign_event_flag    = event_flag_register_ff[`AAM_BIT_REALIGN];
    wire logic divider_mismatch_flag = event_flag_register_ff[`AAM_BIT_MISMATCH];
    wire logic realign_event_mask    = event_mask_register_ff[`AAM_BIT_REALIGN];
    wire logic divider_mismatch_mask = event_mask_register_ff[`AAM_BIT_MISMATCH];

    // events: the mismatch is a level, so the flag is re-set every cycle it lasts
    wire logic divider_mismatch_w = div_phase_a_i != div_phase_b_i;
    aam_pkg::aam_byte_t set_vec_w;
    aam_pkg::aam_byte_t clr_vec_w;
    always_comb
    begin
        set_vec_w = `AAM_BYTE_ZERO;
        set_vec_w[`AAM_BIT_REALIGN]  = realign_pulse_i;
        set_vec_w[`AAM_BIT_MISMATCH] = divider_mismatch_w;
    end
    // only a 1 in the written byte clears; zeros leave the flag alone
    assign clr_vec_w = wr_flags_w ? bus.wdata : `AAM_BYTE_ZERO;

    // set is applied after clear so that an event in the clearing cycle survives
    assign nxt_event_flag_register =
        ((event_flag_register_ff & ~clr_vec_w) | set_vec_w) & `AAM_FLAG_IMPL;

    // mask: reserved bits are not stored and read as zero
    assign nxt_event_mask_register =
        wr_mask_w ? (bus.wdata & `AAM_FLAG_IMPL) : event_mask_register_ff;

    // masks gate only the summary, never the flags themselves
    wire aam_pkg::aam_byte_t live_w = event_flag_register_ff & ~event_mask_register_ff;
    wire logic summary_w = |live_w;

    // flag and mask registers; soft reset presets them like power-on
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            event_flag_register_ff <= `AAM_FLAG_RESET;
            event_mask_register_ff <= `AAM_MASK_RESET;
        end
        else if (soft_reset_i)
        begin
            event_flag_register_ff <= `AAM_FLAG_RESET;
            event_mask_register_ff <= `AAM_MASK_RESET;
        end
        else
        begin
            event_flag_register_ff <= nxt_event_flag_register;
            event_mask_register_ff <= nxt_event_mask_register;
        end
    end

    // pin register; one cycle late, but keeps the pad free of decode glitches
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cal_stat_ff <= 1'b0;
        else
            cal_stat_ff <= cal_status_sel_i ? summary_w : cal_done_i;
    end

    // read mux; unmapped addresses read zero
    aam_pkg::aam_byte_t summary_byte_w;
    always_comb
    begin
        summary_byte_w = `AAM_BYTE_ZERO;
        summary_byte_w[`AAM_BIT_SUMMARY] = summary_w;
    end
    assign bus.rdata = sel_summary_w ? summary_byte_w :
                       sel_flags_w   ? event_flag_register_ff :
                       sel_mask_w    ? event_mask_register_ff : `AAM_BYTE_ZERO;

    assign cal_stat_o      = cal_stat_ff;
    assign summary_alarm_o = summary_w;

    // checks
    // summary bit against the unmasked flags, each bit seen separately
    property p_summary_on;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        (realign_event_flag && !realign_event_mask) ||
        (divider_mismatch_flag && !divider_mismatch_mask) |-> summary_alarm_o;
    endproperty
    a_summary_on: assert property (p_summary_on)
        else $error("summary low with live flag");

    // the pin copies the summary one cycle later while selected
    property p_pin_follow;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        cal_status_sel_i |=> cal_stat_o == $past(summary_alarm_o);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("status pin not tracking summary");

    // a realign pulse leaves the flag set; a soft reset in that cycle presets it set as well
    property p_realign_set;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        realign_pulse_i |=> realign_event_flag;
    endproperty
    a_realign_set: assert property (p_realign_set) else $error("realign event lost");

    // a mismatch held for two cycles keeps the flag set over both
    sequence s_mismatch_2;
        (div_phase_a_i != div_phase_b_i) [*2];
    endsequence
    property p_mismatch_set;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_mismatch_2 |=> divider_mismatch_flag && $past(divider_mismatch_flag);
    endproperty
    a_mismatch_set: assert property (p_mismatch_set)
        else $error("divider mismatch lost");

    // writing a one to the realign flag clears it when no event competes
    sequence s_clear_realign;
        bus.wr_stb && sel_flags_w && bus.wdata[`AAM_BIT_REALIGN] && !realign_pulse_i;
    endsequence
    property p_w1c;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_clear_realign ##1 !realign_pulse_i |-> !realign_event_flag;
    endproperty
    a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

    // soft reset presets the flag register
    property p_soft_preset;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        soft_reset_i |=> event_flag_register_ff == `AAM_FLAG_RESET;
    endproperty
    a_soft_preset: assert property (p_soft_preset) else $error("flags not preset");

    // masked realign flag cannot raise the summary on its own
    property p_mask_realign;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        realign_event_mask && (!divider_mismatch_flag || divider_mismatch_mask)
            |-> !summary_alarm_o;
    endproperty
    a_mask_realign: assert property (p_mask_realign)
        else $error("masked realign in summary");

    // masked mismatch flag cannot raise the summary on its own
    property p_mask_mismatch;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        divider_mismatch_mask && (!realign_event_flag || realign_event_mask)
            |-> !summary_alarm_o;
    endproperty
    a_mask_mismatch: assert property (p_mask_mismatch)
        else $error("masked mismatch in summary");

    // the mask returns to both-masked after a soft reset
    property p_mask_reset;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        soft_reset_i |=> event_mask_register_ff == `AAM_MASK_RESET;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not preset");

    // a set realign flag holds while no one is written to it
    property p_sticky;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        realign_event_flag && !(wr_flags_w && bus.wdata[`AAM_BIT_REALIGN]) |=> realign_event_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped without clear");

    // an event in the clearing cycle wins over the clear
    property p_set_wins;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_flags_w && bus.wdata[`AAM_BIT_REALIGN] && realign_pulse_i |=> realign_event_flag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat simultaneous event");

    // without a live flag the summary stays low
    property p_summary_off;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !(realign_event_flag && !realign_event_mask) &&
        !(divider_mismatch_flag && !divider_mismatch_mask) |-> !summary_alarm_o;
    endproperty
    a_summary_off: assert property (p_summary_off)
        else $error("summary high without live flag");

    // while not selected the pin carries the calibration status one cycle later
    property p_pin_done;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !cal_status_sel_i |=> cal_stat_o == $past(cal_done_i);
    endproperty
    a_pin_done: assert property (p_pin_done)
        else $error("status pin not tracking calibration");

    // a one written to the mismatch flag clears it when the dividers agree
    sequence s_clear_mismatch;
        wr_flags_w && bus.wdata[`AAM_BIT_MISMATCH] && !divider_mismatch_w && !soft_reset_i;
    endsequence
    property p_w1c_mismatch;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_clear_mismatch |=> !divider_mismatch_flag;
    endproperty
    a_w1c_mismatch: assert property (p_w1c_mismatch)
        else $error("write one did not clear mismatch flag");

    // the mismatch flag holds while no one is written to it
    property p_sticky_mismatch;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        divider_mismatch_flag && !(wr_flags_w && bus.wdata[`AAM_BIT_MISMATCH])
            |=> divider_mismatch_flag;
    endproperty
    a_sticky_mismatch: assert property (p_sticky_mismatch)
        else $error("mismatch flag dropped without clear");

    // no flag bit falls unless the flag register was written
    property p_no_fall;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr_flags_w |=>
            (~event_flag_register_ff & $past(event_flag_register_ff)) == `AAM_BYTE_ZERO;
    endproperty
    a_no_fall: assert property (p_no_fall)
        else $error("flag fell without a write");

    // a masked realign flag still records events
    property p_masked_realign_records;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        realign_pulse_i && realign_event_mask |=> realign_event_flag;
    endproperty
    a_masked_realign_records: assert property (p_masked_realign_records)
        else $error("masked realign event not recorded");

    // a masked mismatch flag still records events
    property p_masked_mismatch_records;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        divider_mismatch_w && divider_mismatch_mask |=> divider_mismatch_flag;
    endproperty
    a_masked_mismatch_records: assert property (p_masked_mismatch_records)
        else $error("masked mismatch not recorded");

    // the mask moves only on a host write or a soft reset, so alarms stay masked until the host writes it
    property p_mask_hold;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !wr_mask_w && !soft_reset_i |=> $stable(event_mask_register_ff);
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask changed without a write");
endmodule : aam_alarm_monitor
`default_nettype wire

// ---- include/aam_map.svh ----
// register offsets, field positions, reset values and frame sizes of the alarm monitor
`ifndef AAM_MAP_SVH
`define AAM_MAP_SVH

// register byte addresses on the serial port
`define AAM_ADDR_SUMMARY   15'h02c0
`define AAM_ADDR_FLAGS     15'h02c1
`define AAM_ADDR_MASK      15'h02c2

// field positions
`define AAM_BIT_SUMMARY    0
`define AAM_BIT_MISMATCH   0
`define AAM_BIT_REALIGN    2

// reset values and implemented bits
`define AAM_FLAG_RESET     8'h05
`define AAM_MASK_RESET     8'h05
`define AAM_FLAG_IMPL      8'h05
`define AAM_BYTE_ZERO      8'h00

// serial frame: 1 direction bit, 15 address bits, 8 data bits
`define AAM_SPI_HDR_LAST   5'h0f
`define AAM_SPI_HDR_BITS   5'h10
`define AAM_SPI_FRM_LAST   5'h17
`define AAM_SPI_FRM_BITS   5'h18
`define AAM_SPI_CNT_ONE    5'h01
`define AAM_SPI_RW_POS     14

`endif

// ---- include/aam_pkg.sv ----
// shared types of the alarm monitor
`default_nettype none
package aam_pkg;
    // serial frame progress
    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_HDR,
        SPI_DATA,
        SPI_DONE
    } aam_spi_e;

    typedef logic [14:0] aam_addr_t;
    typedef logic [7:0]  aam_byte_t;
endpackage : aam_pkg
`default_nettype wire

// ---- include/aam_regbus_if.sv ----
// register access carrier between the serial port and the alarm registers
`default_nettype none
interface aam_regbus_if;
    aam_pkg::aam_addr_t addr;    // address of the current frame
    aam_pkg::aam_byte_t wdata;   // write data
    logic               wr_stb;  // one-cycle write strobe
    aam_pkg::aam_byte_t rdata;   // read data for addr

    modport port_side (
        output addr,
        output wdata,
        output wr_stb,
        input  rdata
    );
    modport reg_side (
        input  addr,
        input  wdata,
        input  wr_stb,
        output rdata
    );
endinterface : aam_regbus_if
`default_nettype wire

// ---- hw/aam_spi_port.sv ----
// serial register port: samples the host pins and turns frames into register accesses
`include "aam_map.svh"
`default_nettype none
module aam_spi_port (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // host pins, asynchronous to clk_sys_i
    input  wire logic spi_cs_n_i,
    input  wire logic spi_sclk_i,
    input  wire logic spi_sdi_i,
    output logic      spi_sdo_o,
    output logic      spi_sdo_oe_o,
    // register side
    aam_regbus_if.port_side bus
);
    // two-flop synchronisers; stage one feeds only stage two
    logic cs_s1_ff, cs_s2_ff, sclk_s1_ff, sclk_s2_ff, sclk_s3_ff, sdi_s1_ff, sdi_s2_ff;
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            {cs_s1_ff, cs_s2_ff} <= 2'h3;
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= 3'h0;
            {sdi_s1_ff, sdi_s2_ff} <= 2'h0;
        end
        else
        begin
            {cs_s1_ff, cs_s2_ff} <= {spi_cs_n_i, cs_s1_ff};
            {sclk_s1_ff, sclk_s2_ff, sclk_s3_ff} <= {spi_sclk_i, sclk_s1_ff, sclk_s2_ff};
            {sdi_s1_ff, sdi_s2_ff} <= {spi_sdi_i, sdi_s1_ff};
        end
    end

    // edges seen on the synchronised clock only
    wire logic active_w = !cs_s2_ff;
    wire logic rise_w   = active_w && sclk_s2_ff && !sclk_s3_ff;
    wire logic fall_w   = active_w && !sclk_s2_ff && sclk_s3_ff;

    aam_pkg::aam_spi_e state_ff, nxt_state;
    logic [4:0]         cnt_ff;
    logic [15:0]        shin_ff;
    logic               read_ff;
    logic               load_ff;
    aam_pkg::aam_addr_t addr_ff;
    aam_pkg::aam_byte_t wdata_ff, shout_ff;
    logic               wr_ff;

    // frame progress follows the bit count
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            aam_pkg::SPI_IDLE: if (active_w) nxt_state = aam_pkg::SPI_HDR;
            aam_pkg::SPI_HDR:  if (rise_w && cnt_ff == `AAM_SPI_HDR_LAST)
                                   nxt_state = aam_pkg::SPI_DATA;
            aam_pkg::SPI_DATA: if (rise_w && cnt_ff == `AAM_SPI_FRM_LAST)
                                   nxt_state = aam_pkg::SPI_DONE;
            aam_pkg::SPI_DONE: nxt_state = state_ff;
        endcase
        if (!active_w)
            nxt_state = aam_pkg::SPI_IDLE;
    end

    wire logic hdr_end_w = rise_w && state_ff == aam_pkg::SPI_HDR && cnt_ff == `AAM_SPI_HDR_LAST;
    wire logic frm_end_w = rise_w && state_ff == aam_pkg::SPI_DATA && cnt_ff == `AAM_SPI_FRM_LAST;

    // shifting; a frame longer than 24 bits is ignored past its end
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= aam_pkg::SPI_IDLE;
            cnt_ff   <= 5'h00;
            shin_ff  <= 16'h0000;
            read_ff  <= 1'b0;
            load_ff  <= 1'b0;
            addr_ff  <= 15'h0000;
            wdata_ff <= 8'h00;
            shout_ff <= 8'h00;
            wr_ff    <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            load_ff  <= hdr_end_w && shin_ff[`AAM_SPI_RW_POS];
            wr_ff    <= frm_end_w && !read_ff;
            if (!active_w)
                cnt_ff <= 5'h00;
            else if (rise_w && state_ff != aam_pkg::SPI_DONE)
            begin
                cnt_ff  <= cnt_ff + `AAM_SPI_CNT_ONE;
                shin_ff <= {shin_ff[14:0], sdi_s2_ff};
            end
            if (hdr_end_w)
            begin
                read_ff <= shin_ff[`AAM_SPI_RW_POS];
                addr_ff <= {shin_ff[13:0], sdi_s2_ff};
            end
            if (frm_end_w)
                wdata_ff <= {shin_ff[6:0], sdi_s2_ff};
            // read data is caught once the address is known, then shifted on falling edges
            if (load_ff)
                shout_ff <= bus.rdata;
            else if (fall_w && state_ff == aam_pkg::SPI_DATA && cnt_ff > `AAM_SPI_HDR_BITS)
                shout_ff <= {shout_ff[6:0], 1'b0};
        end
    end

    assign bus.addr     = addr_ff;
    assign bus.wdata    = wdata_ff;
    assign bus.wr_stb   = wr_ff;
    assign spi_sdo_o    = shout_ff[7];
    assign spi_sdo_oe_o = active_w && read_ff && state_ff == aam_pkg::SPI_DATA;

    // a write strobe lasts exactly one cycle
    property p_wr_single;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_ff |=> !wr_ff;
    endproperty
    a_wr_single: assert property (p_wr_single)
        else $error("write strobe longer than one cycle");
endmodule : aam_spi_port
`default_nettype wire

// ---- tb/aam_host_model.sv ----
// host model of the serial register port: drives 24-bit frames and collects read data
`default_nettype none
module aam_host_model (
    // clock
    input  wire logic clk_sys_i,
    // serial pins
    output logic      spi_cs_n_o,
    output logic      spi_sclk_o,
    output logic      spi_sdi_o,
    input  wire logic spi_sdo_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // sclk half period in clk_sys cycles, above the 3-cycle minimum the synchroniser needs
    localparam int HALF = 5;

    // idle pins: chip select off, sclk stands still low between frames
    initial
    begin
        spi_cs_n_o = 1'b1;
        spi_sclk_o = 1'b0;
        spi_sdi_o  = 1'b0;
    end

    // one frame, msb first; sdi changes only while sclk is low, sdo taken just before each of the last 8 rises
    task automatic frame(input logic rd, input aam_pkg::aam_addr_t addr,
                         input aam_pkg::aam_byte_t wdat, output aam_pkg::aam_byte_t rdat);
        logic [23:0] word;
        word = {rd, addr, wdat};
        rdat = 8'h00;
        @(negedge clk_sys_i);
        spi_cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            spi_sdi_o = word[i];
            repeat (HALF) @(negedge clk_sys_i);
            if (i < 8)
            begin
                rdat[i] = spi_sdo_i;
            end
            spi_sclk_o = 1'b1;
            repeat (HALF) @(negedge clk_sys_i);
            spi_sclk_o = 1'b0;
        end
        // keep select low past the write strobe, then leave a gap well over 3 cycles
        repeat (HALF) @(negedge clk_sys_i);
        spi_cs_n_o = 1'b1;
        spi_sdi_o  = ~spi_sdi_o; // released line shows no stale value
        repeat (2 * HALF) @(negedge clk_sys_i);
    endtask : frame
endmodule : aam_host_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the alarm monitor: registers, events, masks and status pin
`include "aam_map.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic               clk_sys_i;
    logic               rst_n_i;
    logic               soft_reset_i;
    logic               spi_cs_n;
    logic               spi_sclk;
    logic               spi_sdi;
    logic               spi_sdo, spi_sdo_oe;
    logic               realign_pulse_i;
    logic [3:0]         div_phase_a_i;
    logic [3:0]         div_phase_b_i;
    logic               cal_status_sel_i;
    logic               cal_done_i;
    logic               cal_stat_o;
    logic               summary_alarm_o;
    int                 errors;
    int                 total_checks;
    int unsigned        seed_val;
    aam_pkg::aam_byte_t rd;
    aam_pkg::aam_byte_t exp_flags;
    aam_pkg::aam_byte_t exp_mask;
    aam_pkg::aam_byte_t m;

    // 25 MHz system clock
    initial clk_sys_i = 1'b0;
    always #20 clk_sys_i = ~clk_sys_i;

    aam_alarm_monitor #(.DIV_W(4)) uut (
        .clk_sys_i        (clk_sys_i),
        .rst_n_i          (rst_n_i),
        .soft_reset_i     (soft_reset_i),
        .spi_cs_n_i       (spi_cs_n),
        .spi_sclk_i       (spi_sclk),
        .spi_sdi_i        (spi_sdi),
        .spi_sdo_o        (spi_sdo),
        .spi_sdo_oe_o     (spi_sdo_oe),
        .realign_pulse_i  (realign_pulse_i),
        .div_phase_a_i    (div_phase_a_i),
        .div_phase_b_i    (div_phase_b_i),
        .cal_status_sel_i (cal_status_sel_i),
        .cal_done_i       (cal_done_i),
        .cal_stat_o       (cal_stat_o),
        .summary_alarm_o  (summary_alarm_o)
    );

    aam_host_model u_host (
        .clk_sys_i  (clk_sys_i),
        .spi_cs_n_o (spi_cs_n),
        .spi_sclk_o (spi_sclk),
        .spi_sdi_o  (spi_sdi),
        .spi_sdo_i  (spi_sdo_oe ? spi_sdo : ~spi_sdo) // released line shows the inverse
    );

    // compare one value and count it
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test

    // summary expected from flags and mask, reserved bits ignored
    function automatic logic [7:0] exp_sum(input logic [7:0] f, input logic [7:0] k);
        return {7'h00, |(f & ~k & `AAM_FLAG_IMPL)};
    endfunction : exp_sum

    task automatic reg_wr(input aam_pkg::aam_addr_t a, input aam_pkg::aam_byte_t d);
        aam_pkg::aam_byte_t unused;
        u_host.frame(1'b0, a, d, unused);
    endtask : reg_wr

    task automatic reg_rd(input aam_pkg::aam_addr_t a, output aam_pkg::aam_byte_t d);
        u_host.frame(1'b1, a, 8'h00, d);
    endtask : reg_rd

    // one-cycle event: kind[1] realign pulse, kind[0] divider mismatch
    task automatic event_in(input logic [1:0] kind);
        @(negedge clk_sys_i);
        div_phase_a_i   = 4'($urandom);
        div_phase_b_i   = kind[0] ? div_phase_a_i ^ 4'($urandom_range(15, 1)) : div_phase_a_i;
        realign_pulse_i = kind[1];
        @(negedge clk_sys_i);
        div_phase_b_i   = div_phase_a_i;
        realign_pulse_i = 1'b0;
        exp_flags = exp_flags | {5'h00, kind[1], 1'b0, kind[0]};
    endtask : event_in

    // main sequence
    initial
    begin
        errors = 0;
        total_checks = 0;
        rst_n_i = 1'b0;
        soft_reset_i = 1'b0;
        realign_pulse_i = 1'b0;
        div_phase_a_i = 4'h0;
        div_phase_b_i = 4'h0;
        cal_status_sel_i = 1'b0;
        cal_done_i = 1'b0;
        seed_val = $urandom(45891);
        repeat (4) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
        reg_rd(`AAM_ADDR_FLAGS, rd);
        check(rd, 8'h05);
        reg_rd(`AAM_ADDR_MASK, rd);
        check(rd, 8'h05);
        reg_rd(`AAM_ADDR_SUMMARY, rd);
        check(rd, 8'h00);
        reg_wr(`AAM_ADDR_SUMMARY, 8'hff);
        reg_rd(15'h02c3, rd);
        check(rd, 8'h00); // unmapped place reads zero
        $display("test reset_values done");
        // sticky flag: a zero write and a write to the other bit leave it
        reg_wr(`AAM_ADDR_FLAGS, 8'hff);
        reg_rd(`AAM_ADDR_FLAGS, rd);
        check(rd, 8'h00);
        exp_flags = 8'h00;
        event_in(2'b10);
        reg_wr(`AAM_ADDR_FLAGS, 8'h00);
        reg_wr(`AAM_ADDR_FLAGS, 8'h01);
        reg_rd(`AAM_ADDR_FLAGS, rd);
        check(rd, 8'h04);
        check({7'h00, summary_alarm_o}, 8'h00);
        reg_wr(`AAM_ADDR_MASK, 8'h00);
        reg_rd(`AAM_ADDR_SUMMARY, rd);
        check(rd, 8'h01);
        reg_wr(`AAM_ADDR_MASK, 8'h04);
        check({7'h00, summary_alarm_o}, 8'h00);
        // clear racing a held event: the event wins
        realign_pulse_i = 1'b1;
        reg_wr(`AAM_ADDR_FLAGS, 8'h04);
        realign_pulse_i = 1'b0;
        reg_rd(`AAM_ADDR_FLAGS, rd);
        check(rd, 8'h04);
        reg_wr(`AAM_ADDR_FLAGS, 8'h05);
        exp_flags = 8'h00;
        event_in(2'b01);
        reg_wr(`AAM_ADDR_MASK, 8'h01);
        reg_rd(`AAM_ADDR_FLAGS, rd);
        check(rd, 8'h01);
        check({7'h00, summary_alarm_o}, 8'h00);
        reg_wr(`AAM_ADDR_MASK, 8'h04);
        check({7'h00, summary_alarm_o}, 8'h01);
        $display("test flags_and_masks done");
        // soft reset presets both registers
        reg_wr(`AAM_ADDR_FLAGS, 8'h05);
        @(negedge clk_sys_i);
        soft_reset_i = 1'b1;
        @(negedge clk_sys_i);
        soft_reset_i = 1'b0;
        reg_rd(`AAM_ADDR_FLAGS, rd);
        check(rd, 8'h05);
        reg_rd(`AAM_ADDR_MASK, rd);
        check(rd, 8'h05);
        $display("test soft_reset done");
        // random masks, events and pin routing
        for (int n = 0; n < 10; n++)
        begin
            m = 8'($urandom);
            cal_status_sel_i = 1'($urandom);
            cal_done_i = 1'($urandom);
            reg_wr(`AAM_ADDR_FLAGS, 8'h05);
            exp_flags = 8'h00;
            reg_wr(`AAM_ADDR_MASK, m);
            exp_mask = m & `AAM_FLAG_IMPL;
            event_in(2'($urandom));
            reg_rd(`AAM_ADDR_FLAGS, rd);
            check(rd, exp_flags);
            reg_rd(`AAM_ADDR_MASK, rd);
            check(rd, exp_mask);
            reg_rd(`AAM_ADDR_SUMMARY, rd);
            check(rd, exp_sum(exp_flags, exp_mask));
            check({7'h00, cal_stat_o}, cal_status_sel_i ? exp_sum(exp_flags, exp_mask)
                                                        : {7'h00, cal_done_i});
        end
        $display("test random_alarms done");
        stop_test();
    end

    // watchdog: the tests need about 20000 cycles
    initial
    begin
        repeat (60000) @(posedge clk_sys_i);
        errors++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
